// >>> src/uxd_regs.svh
// field positions, opcode values and register map of the view export decoder
`ifndef UXD_REGS_SVH
`define UXD_REGS_SVH
`define UXD_W0_VIEW     3:0
`define UXD_W0_OP       9:4
`define UXD_W0_IDX      12:11
`define UXD_W0_TYPE     14:13
`define UXD_W0_SRC      21:15
`define UXD_W0_REL      22
`define UXD_W0_COORD    29:23
`define UXD_W0_ES       31:30
`define UXD_W1_ASIZE    11:0
`define UXD_W1_STRIDE   7:0
`define UXD_W1_MASK     15:12
`define UXD_W1_BURST    19:16
`define UXD_W1_VPM      20
`define UXD_W1_EOP      21
`define UXD_W1_FLOW     29:22
`define UXD_W1_STRM     25:24
`define UXD_W1_BUFN     23:22
`define UXD_W1_MARK     30
`define UXD_W1_BAR      31
`define UXD_TYPE_IND    0
`define UXD_TYPE_ACK    1
`define UXD_IDX_NONE    2'h0
`define UXD_IDX_0       2'h1
`define UXD_IDX_1       2'h2
`define UXD_IDX_BAD     2'h3
`define UXD_ES_BAD      2'h3
`define UXD_OP_RSV_LO   6'h14
`define UXD_OP_RSV_HI   6'h1f
`define UXD_OP_RSV_33   6'h21
`define UXD_OP_RTN_LO   6'h24
`define UXD_OP_RTN_HI   6'h33
`define UXD_OP_RTN_OFS  6'h20
`define UXD_FLOW_STR_LO 8'h40
`define UXD_FLOW_STR_HI 8'h4f
`define UXD_FLOW_SCR    8'h50
`define UXD_FLOW_CL     8'h57
`define UXD_FLOW_CL_CMB 8'h5c
`define UXD_MASK_RAW    4'h1
`define UXD_MASK_FULL   4'hf
`define UXD_MAXDW_TYPED 3'h4
`define UXD_MAXDW_CL    3'h2
`define UXD_MAXDW_ONE   3'h1
`define UXD_REG_CTRL    4'h0
`define UXD_REG_STAT    4'h4
`define UXD_REG_COUNT   4'h8
`define UXD_REG_LAST    4'hc
`define UXD_CTRL_EN     0
`define UXD_CTRL_RESUME 1
`define UXD_EN_RST      1'b1
`endif

// >>> src/uxd_pkg.sv
// types shared by the view export decoder modules
package uxd_pkg;
    typedef enum logic [5:0] {
        UXD_NOP = 6'h00, UXD_STORE_TYPED = 6'h01, UXD_STORE_RAW = 6'h02,
        UXD_STORE_RAW_FZ = 6'h03, UXD_CMPX_INT = 6'h04, UXD_CMPX_FLT = 6'h05,
        UXD_CMPX_FZ = 6'h06, UXD_ADD = 6'h07, UXD_SUB = 6'h08,
        UXD_RSUB = 6'h09, UXD_MIN_INT = 6'h0a, UXD_MIN_UINT = 6'h0b,
        UXD_MAX_INT = 6'h0c, UXD_MAX_UINT = 6'h0d, UXD_AND = 6'h0e,
        UXD_OR = 6'h0f, UXD_XOR = 6'h10, UXD_MSKOR = 6'h11,
        UXD_INC_UINT = 6'h12, UXD_DEC_UINT = 6'h13, UXD_NOP_RTN = 6'h20,
        UXD_XCHG = 6'h22, UXD_XCHG_FZ = 6'h23
    } uxd_kind_t;
    typedef struct packed {
        uxd_kind_t   kind;
        logic        returns;
        logic        ret_float;
        logic        ret_uint;
        logic        flush;
        logic        reserved;
        logic [2:0]  max_dwords;
    } uxd_cls_t;
    typedef struct packed {
        logic [3:0]  view_sel;
        logic [5:0]  view_op;
        uxd_cls_t    cls;
        logic [1:0]  exp_type;
        logic [6:0]  src_reg;
        logic [6:0]  coord_reg;
        logic [2:0]  elem_dw;
        logic [12:0] array_len;
        logic [8:0]  stride;
        logic [3:0]  comp_mask;
        logic [4:0]  burst_len;
        logic [6:0]  burst_dw;
        logic        valid_pix;
        logic        final_ins;
        logic [7:0]  flow_op;
        logic        stream;
        logic [1:0]  stream_num;
        logic [1:0]  buffer_num;
        logic        mark;
        logic        barrier;
        logic        illegal;
    } uxd_dec_t;
endpackage : uxd_pkg

// >>> src/uxd_cls_if.sv
// carries a view operation code to the classifier and its class back
`timescale 1ns/100ps
interface uxd_cls_if;
    logic [5:0]       code;
    uxd_pkg::uxd_cls_t cls;
    modport classifier (input code, output cls);
    modport user       (output code, input cls);
endinterface : uxd_cls_if

// >>> src/uxd_op_class.sv
// classifies a view operation code into kind, return form and size
`timescale 1ns/100ps
`include "uxd_regs.svh"
module uxd_op_class (
    uxd_cls_if.classifier cif
);
    logic             is_rtn;
    logic [5:0]       base;
    logic             rsv;

    always_comb begin
        is_rtn = (cif.code >= `UXD_OP_RTN_LO) && (cif.code <= `UXD_OP_RTN_HI);
        // return forms reuse the plain operation table
        base = is_rtn ? cif.code - `UXD_OP_RTN_OFS : cif.code; // RL11
        rsv = ((cif.code >= `UXD_OP_RSV_LO) && (cif.code <= `UXD_OP_RSV_HI))
            || (cif.code == `UXD_OP_RSV_33)
            || (cif.code > `UXD_OP_RTN_HI); // RL9
        cif.cls.reserved = rsv;
        cif.cls.kind = rsv ? uxd_pkg::UXD_NOP : uxd_pkg::uxd_kind_t'(base);
        cif.cls.returns = !rsv && (is_rtn
            || (base == uxd_pkg::UXD_NOP_RTN)
            || (base == uxd_pkg::UXD_XCHG)
            || (base == uxd_pkg::UXD_XCHG_FZ)); // RL9 RL10 RL11
        cif.cls.ret_float = (is_rtn && ((base == uxd_pkg::UXD_CMPX_FLT)
            || (base == uxd_pkg::UXD_CMPX_FZ)))
            || (base == uxd_pkg::UXD_XCHG_FZ); // RL10 RL11
        cif.cls.ret_uint = is_rtn && ((base == uxd_pkg::UXD_INC_UINT)
            || (base == uxd_pkg::UXD_DEC_UINT)); // RL11
        cif.cls.flush = (base == uxd_pkg::UXD_STORE_RAW_FZ)
            || (base == uxd_pkg::UXD_CMPX_FZ)
            || (base == uxd_pkg::UXD_XCHG_FZ); // RL3 RL4 RL10
        cif.cls.max_dwords = (!rsv && base == uxd_pkg::UXD_STORE_TYPED)
            ? `UXD_MAXDW_TYPED : `UXD_MAXDW_ONE; // RL2
    end
endmodule : uxd_op_class

// >>> src/uxd_decoder.sv
// view export instruction decoder with avalon control and status
//
// How it works
// RL1: view selector plus optional index register
// RL2: code one typed store, up to four dwords
// RL3: raw store; only code for cacheless views
// RL4: codes four to six compare-exchange
// RL5: codes seven to nine integer add/subtract
// RL6: codes ten to thirteen min and max
// RL7: codes fourteen to seventeen bitwise updates
// RL8: codes eighteen, nineteen wrapping increment, decrement
// RL9: reserved codes; code thirty-two internal flush
// RL10: codes thirty-four, thirty-five exchange returning value
// RL11: codes thirty-six to fifty-one repeat ops with return
// RL12: export type selects index offset, acknowledge
// RL13: source register holds data or operands
// RL14: loop-relative flag adds loop index
// RL15: coordinate register scaled by element size
// RL16: element size one, two, four dwords
// RL17: array size or cacheless dword stride
// RL18: component mask, raw one, others full
// RL19: burst length is field plus one
// RL20: valid pixel mode passed through
// RL21: final instruction stops further issue
// RL22: stream writes give stream and buffer
// RL23: mark flag passed for next acknowledge
// RL24: barrier holds until earlier work completes
// RL25: illegal fields flagged, no memory access
`timescale 1ns/100ps
`include "uxd_regs.svh"
module uxd_decoder (
    input  wire logic        ref_clk,
    input  wire logic        rst_n,
    input  wire logic [3:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    input  wire logic [3:0]  avs_byteenable,
    output logic      [31:0] avs_readdata,
    output logic             avs_waitrequest,
    input  wire logic        ins_valid,
    output logic             ins_ready,
    input  wire logic [31:0] ins_word0,
    input  wire logic [31:0] ins_word1,
    input  wire logic [7:0]  loop_index_value,
    input  wire logic [3:0]  view_index0,
    input  wire logic [3:0]  view_index1,
    input  wire logic        prior_done,
    output logic             dec_valid,
    input  wire logic        dec_ready,
    output logic      [3:0]  dec_view_selector,
    output logic      [5:0]  dec_view_operation_code,
    output logic      [5:0]  dec_op_kind,
    output logic             dec_returns,
    output logic             dec_ret_float,
    output logic             dec_ret_uint,
    output logic             dec_flush_denorm,
    output logic      [2:0]  dec_max_dwords,
    output logic      [1:0]  dec_export_type,
    output logic             dec_write_with_index_offset,
    output logic             dec_write_ack,
    output logic      [6:0]  dec_source_reg_number,
    output logic      [6:0]  dec_address_coord_reg,
    output logic      [2:0]  dec_elem_dwords,
    output logic      [12:0] dec_array_len,
    output logic      [8:0]  dec_stride,
    output logic      [3:0]  dec_comp_mask,
    output logic      [4:0]  dec_burst_len,
    output logic      [6:0]  dec_burst_dwords,
    output logic             dec_valid_pixel,
    output logic             dec_program_final_flag,
    output logic      [7:0]  dec_flow_operation_code,
    output logic             dec_stream_write,
    output logic      [1:0]  dec_stream_num,
    output logic      [1:0]  dec_buffer_num,
    output logic             dec_mark,
    output logic             dec_barrier,
    output logic             dec_illegal,
    output logic             dec_mem_access
);
    function automatic logic [2:0] elem_dwords(input logic [1:0] es);
        unique case (es)
            2'h0:    elem_dwords = 3'h1;
            2'h1:    elem_dwords = 3'h2;
            2'h2:    elem_dwords = 3'h4;
            default: elem_dwords = 3'h0;
        endcase
    endfunction : elem_dwords

    function automatic logic [3:0] view_with_index(
        input logic [3:0] sel,
        input logic [1:0] mode,
        input logic [3:0] ix0,
        input logic [3:0] ix1);
        unique case (mode)
            `UXD_IDX_0: view_with_index = sel + ix0;
            `UXD_IDX_1: view_with_index = sel + ix1;
            default:    view_with_index = sel;
        endcase
    endfunction : view_with_index

    uxd_cls_if cif ();
    uxd_op_class u_cls (
        .cif (cif)
    );

    uxd_pkg::uxd_dec_t dec_q;
    uxd_pkg::uxd_dec_t dec_d;
    logic              valid_q;
    logic              valid_d;
    logic              halted_q;
    logic              halted_d;
    logic              en_q;
    logic              en_d;
    logic              ill_seen_q;
    logic              ill_seen_d;
    logic              mask_warn_q;
    logic              mask_warn_d;
    logic [31:0]       count_q;
    logic [31:0]       count_d;
    logic [31:0]       rdata_q;
    logic [31:0]       rdata_d;
    logic              ack_q;
    logic              ack_d;
    logic              ins_fire;
    logic              cacheless;
    logic              is_raw;
    logic              mask_bad;
    logic              wr_ok;
    logic              rd_ok;

    assign cif.code = ins_word0[`UXD_W0_OP]; // RL2

    // barrier and final stop are folded into the ready
    always_comb begin
        ins_ready = en_q && !halted_q && (!valid_q || dec_ready)
            && !(ins_word1[`UXD_W1_BAR] && !prior_done); // RL24 RL21
        ins_fire = ins_valid && ins_ready;
    end

    always_comb begin
        cacheless = (ins_word1[`UXD_W1_FLOW] == `UXD_FLOW_CL)
            || (ins_word1[`UXD_W1_FLOW] == `UXD_FLOW_CL_CMB);
        is_raw = (cif.cls.kind == uxd_pkg::UXD_STORE_RAW)
            || (cif.cls.kind == uxd_pkg::UXD_STORE_RAW_FZ);
        mask_bad = (cif.cls.kind != uxd_pkg::UXD_NOP) && (is_raw
            ? ins_word1[`UXD_W1_MASK] != `UXD_MASK_RAW
            : ins_word1[`UXD_W1_MASK] != `UXD_MASK_FULL); // RL18
        dec_d = dec_q;
        dec_d.view_sel = view_with_index(ins_word0[`UXD_W0_VIEW],
            ins_word0[`UXD_W0_IDX], view_index0, view_index1); // RL1
        dec_d.view_op = ins_word0[`UXD_W0_OP];
        dec_d.cls = cif.cls; // RL4 RL5 RL6 RL7 RL8 RL9 RL10 RL11
        if (cacheless && cif.cls.kind == uxd_pkg::UXD_STORE_RAW) begin
            dec_d.cls.max_dwords = `UXD_MAXDW_CL; // RL3
        end
        dec_d.exp_type = ins_word0[`UXD_W0_TYPE]; // RL12
        dec_d.src_reg = ins_word0[`UXD_W0_REL]
            ? ins_word0[`UXD_W0_SRC] + loop_index_value[6:0]
            : ins_word0[`UXD_W0_SRC]; // RL13 RL14
        dec_d.coord_reg = ins_word0[`UXD_W0_COORD]; // RL15
        dec_d.elem_dw = elem_dwords(ins_word0[`UXD_W0_ES]); // RL16
        dec_d.array_len = {1'b0, ins_word1[`UXD_W1_ASIZE]} + 13'h1; // RL17
        dec_d.stride = {1'b0, ins_word1[`UXD_W1_STRIDE]} + 9'h1; // RL17
        dec_d.comp_mask = ins_word1[`UXD_W1_MASK]; // RL18
        dec_d.burst_len = {1'b0, ins_word1[`UXD_W1_BURST]} + 5'h1; // RL19
        dec_d.burst_dw = 7'(dec_d.burst_len * dec_d.elem_dw); // RL16
        dec_d.valid_pix = ins_word1[`UXD_W1_VPM]; // RL20
        dec_d.final_ins = ins_word1[`UXD_W1_EOP]; // RL21
        dec_d.flow_op = ins_word1[`UXD_W1_FLOW]; // RL22
        dec_d.stream = (ins_word1[`UXD_W1_FLOW] >= `UXD_FLOW_STR_LO)
            && (ins_word1[`UXD_W1_FLOW] <= `UXD_FLOW_STR_HI); // RL22
        dec_d.stream_num = ins_word1[`UXD_W1_STRM]; // RL22
        dec_d.buffer_num = ins_word1[`UXD_W1_BUFN]; // RL22
        dec_d.mark = ins_word1[`UXD_W1_MARK]; // RL23
        dec_d.barrier = ins_word1[`UXD_W1_BAR]; // RL24
        dec_d.illegal = cif.cls.reserved
            || (ins_word0[`UXD_W0_IDX] == `UXD_IDX_BAD)
            || (ins_word0[`UXD_W0_ES] == `UXD_ES_BAD)
            || (cacheless && cif.cls.kind != uxd_pkg::UXD_STORE_RAW)
            ; // RL25 RL3
        if (!ins_fire) begin
            dec_d = dec_q;
        end
        valid_d = ins_fire || (valid_q && !dec_ready);
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            dec_q   <= '0;
            valid_q <= 1'b0;
        end else begin
            dec_q   <= dec_d;
            valid_q <= valid_d;
        end
    end

    // scratch length only meaningful for the scratch flow code
    always_comb begin
        dec_valid                   = valid_q;
        dec_view_selector           = dec_q.view_sel;
        dec_view_operation_code     = dec_q.view_op;
        dec_op_kind                 = dec_q.cls.kind;
        dec_returns                 = dec_q.cls.returns;
        dec_ret_float               = dec_q.cls.ret_float;
        dec_ret_uint                = dec_q.cls.ret_uint;
        dec_flush_denorm            = dec_q.cls.flush;
        dec_max_dwords              = dec_q.cls.max_dwords;
        dec_export_type             = dec_q.exp_type;
        dec_write_with_index_offset = dec_q.exp_type[`UXD_TYPE_IND]; // RL12
        dec_write_ack               = dec_q.exp_type[`UXD_TYPE_ACK]; // RL12
        dec_source_reg_number       = dec_q.src_reg;
        dec_address_coord_reg       = dec_q.coord_reg;
        dec_elem_dwords             = dec_q.elem_dw;
        dec_array_len               = dec_q.array_len;
        dec_stride                  = dec_q.stride;
        dec_comp_mask               = dec_q.comp_mask;
        dec_burst_len               = dec_q.burst_len;
        dec_burst_dwords            = dec_q.burst_dw;
        dec_valid_pixel             = dec_q.valid_pix;
        dec_program_final_flag      = dec_q.final_ins;
        dec_flow_operation_code     = dec_q.flow_op;
        dec_stream_write            = dec_q.stream;
        dec_stream_num              = dec_q.stream_num;
        dec_buffer_num              = dec_q.buffer_num;
        dec_mark                    = dec_q.mark;
        dec_barrier                 = dec_q.barrier;
        dec_illegal                 = dec_q.illegal;
        dec_mem_access              = valid_q && !dec_q.illegal; // RL25
    end

    // status and control; set by hardware wins over software clear
    always_comb begin
        // writes land on the edge after the wait state ends
        wr_ok = avs_write && ack_q && avs_byteenable[0];
        rd_ok = avs_read && !ack_q;
        ack_d = (avs_read || avs_write) && !ack_q;
        avs_waitrequest = (avs_read || avs_write) && !ack_q;
        en_d = en_q;
        if (wr_ok && avs_address == `UXD_REG_CTRL) begin
            en_d = avs_writedata[`UXD_CTRL_EN];
        end
        halted_d = halted_q;
        if (wr_ok && avs_address == `UXD_REG_CTRL
            && avs_writedata[`UXD_CTRL_RESUME]) begin
            halted_d = 1'b0;
        end
        if (ins_fire && ins_word1[`UXD_W1_EOP]) begin
            halted_d = 1'b1; // RL21
        end
        ill_seen_d = ill_seen_q;
        mask_warn_d = mask_warn_q;
        if (wr_ok && avs_address == `UXD_REG_STAT) begin
            ill_seen_d = ill_seen_q && !avs_writedata[1];
            mask_warn_d = mask_warn_q && !avs_writedata[2];
        end
        if (ins_fire && dec_d.illegal) begin
            ill_seen_d = 1'b1; // RL25
        end
        if (ins_fire && mask_bad) begin
            mask_warn_d = 1'b1; // RL18
        end
        count_d = ins_fire ? count_q + 32'h1 : count_q;
        rdata_d = 32'h0;
        if (rd_ok) begin
            unique case (avs_address)
                `UXD_REG_CTRL:  rdata_d = {31'h0, en_q};
                `UXD_REG_STAT:  rdata_d = {28'h0, valid_q, mask_warn_q,
                                           ill_seen_q, halted_q};
                `UXD_REG_COUNT: rdata_d = count_q;
                `UXD_REG_LAST:  rdata_d = {18'h0, dec_q.flow_op,
                                           dec_q.view_op};
                default:        rdata_d = 32'h0;
            endcase
        end else if (ack_q) begin
            rdata_d = rdata_q;
        end
        avs_readdata = rdata_q;
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            en_q        <= `UXD_EN_RST;
            halted_q    <= 1'b0;
            ill_seen_q  <= 1'b0;
            mask_warn_q <= 1'b0;
            count_q     <= 32'h0;
            rdata_q     <= 32'h0;
            ack_q       <= 1'b0;
        end else begin
            en_q        <= en_d;
            halted_q    <= halted_d;
            ill_seen_q  <= ill_seen_d;
            mask_warn_q <= mask_warn_d;
            count_q     <= count_d;
            rdata_q     <= rdata_d;
            ack_q       <= ack_d;
        end
    end

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);

    sequence s_eop_taken;
        ins_fire && ins_word1[`UXD_W1_EOP];
    endsequence
    sequence s_stopped;
        halted_q && !ins_ready;
    endsequence

    view_index_a: assert property ( // RL1
        ins_fire && ins_word0[`UXD_W0_IDX] == `UXD_IDX_1 |=>
        dec_view_selector == 4'($past(ins_word0[`UXD_W0_VIEW])
            + $past(view_index1)))
        else $error("view selector not offset by index register 1");
    loop_rel_a: assert property ( // RL14
        ins_fire && !ins_word0[`UXD_W0_REL] |=>
        dec_source_reg_number == $past(ins_word0[`UXD_W0_SRC]))
        else $error("absolute source register altered");
    elem_size_a: assert property ( // RL16
        dec_valid && !dec_illegal |->
        dec_elem_dwords inside {3'h1, 3'h2, 3'h4}
        && dec_burst_dwords == 7'(dec_burst_len * dec_elem_dwords))
        else $error("element size or burst scaling wrong");
    illegal_op_a: assert property ( // RL25
        ins_fire && (ins_word0[`UXD_W0_ES] == `UXD_ES_BAD
        || ins_word0[`UXD_W0_IDX] == `UXD_IDX_BAD) |=>
        dec_illegal && !dec_mem_access)
        else $error("illegal fields not flagged");
    final_stop_a: assert property ( // RL21
        s_eop_taken ##1 s_stopped |=> halted_q || $past(wr_ok))
        else $error("issue resumed after final instruction");
    final_halt_a: assert property ( // RL21
        s_eop_taken |=> s_stopped)
        else $error("final instruction did not stop issue");
    barrier_a: assert property ( // RL24
        ins_word1[`UXD_W1_BAR] && !prior_done |-> !ins_ready)
        else $error("barrier instruction accepted early");
    stream_sel_a: assert property ( // RL22
        ins_fire && ins_word1[`UXD_W1_FLOW] == 8'h49 |=>
        dec_stream_write && dec_stream_num == 2'h2
        && dec_buffer_num == 2'h1)
        else $error("stream or buffer number wrong");
    burst_len_a: assert property ( // RL19
        dec_valid |-> dec_burst_len >= 5'h1 && dec_burst_len <= 5'h10)
        else $error("burst length out of range");
    cacheless_a: assert property ( // RL3
        ins_fire && ins_word1[`UXD_W1_FLOW] == `UXD_FLOW_CL
        && ins_word0[`UXD_W0_OP] != 6'h02 |=> dec_illegal)
        else $error("non-raw cacheless operation not flagged");
    hold_a: assert property (
        dec_valid && !dec_ready |=> dec_valid && $stable(dec_q))
        else $error("decoded instruction changed while stalled");
    // classifier has no clock of its own, so its checks live here
    rtn_map_a: assert property ( // RL11
        (cif.code == `UXD_OP_RTN_LO) |->
        (cif.cls.kind == uxd_pkg::UXD_CMPX_INT) && cif.cls.returns)
        else $error("first return code not mapped to int compare-exchange");
    rsv_kind_a: assert property ( // RL9
        cif.cls.reserved |-> (cif.cls.kind == uxd_pkg::UXD_NOP)
        && !cif.cls.returns)
        else $error("reserved code classified as live operation");
endmodule : uxd_decoder

// >>> tb/uxd_export_model.sv
// export unit stand-in: takes decodes at once or after a stall
`timescale 1ns/100ps
module uxd_export_model (
    input  wire logic ref_clk,
    input  wire logic rst_n,
    input  wire logic fast,
    input  wire logic dec_valid,
    output logic      dec_ready
);
    logic [1:0] wait_q;
    logic [1:0] wait_d;
    always_comb begin
        wait_d = (dec_valid && !dec_ready) ? wait_q + 2'h1 : 2'h0;
    end
    always_ff @(posedge ref_clk) begin
        wait_q <= rst_n ? wait_d : 2'h0;
    end
    // slow mode waits two cycles so the held decode gets exercised
    assign dec_ready = fast || (wait_q == 2'h2);
endmodule : uxd_export_model

// >>> tb/uxd_decoder_bench.sv
// register and decode sequences for the view export decoder
`timescale 1ns/100ps
module uxd_decoder_bench;
    logic ref_clk = 0, rst_n = 0, avs_read = 0, avs_write = 0, fast = 0;
    logic ins_valid = 0, prior_done = 1;
    logic [3:0] avs_address = 4'h0, avs_byteenable = 4'hf;
    logic [3:0] view_index0 = 4'h5, view_index1 = 4'h9;
    logic [7:0] loop_index_value = 8'h03;
    logic [31:0] avs_writedata = 32'h0, ins_word0 = 32'h0, ins_word1 = 32'h0;
    logic [31:0] avs_readdata, q;
    logic avs_waitrequest, ins_ready, dec_valid, dec_ready, dec_returns;
    logic dec_illegal, dec_mem_access, dec_stream_write, dec_program_final_flag;
    logic [3:0] dec_view_selector;
    logic [5:0] dec_op_kind;
    logic [6:0] dec_source_reg_number;
    logic [1:0] dec_stream_num, dec_buffer_num;
    logic [4:0] dec_burst_len;
    int n_fail = 0, check_count = 0;
    uxd_decoder dut (.*, .dec_view_operation_code(), .dec_ret_float(),
        .dec_ret_uint(), .dec_flush_denorm(), .dec_max_dwords(),
        .dec_export_type(), .dec_write_with_index_offset(), .dec_write_ack(),
        .dec_address_coord_reg(), .dec_elem_dwords(), .dec_array_len(),
        .dec_stride(), .dec_comp_mask(), .dec_burst_dwords(),
        .dec_valid_pixel(), .dec_flow_operation_code(), .dec_mark(),
        .dec_barrier());
    uxd_export_model exp_u (.ref_clk(ref_clk), .rst_n(rst_n), .fast(fast),
        .dec_valid(dec_valid), .dec_ready(dec_ready));
    always #20 ref_clk = ~ref_clk;
    function automatic logic [31:0] mk0(logic [1:0] es, logic rel,
        logic [6:0] src, logic [1:0] ix, logic [5:0] op, logic [3:0] v);
        return {es, 7'h11, rel, src, 2'h0, ix, 1'b0, op, v};
    endfunction : mk0
    function automatic logic [31:0] mk1(logic b, logic e, logic [7:0] f,
        logic [3:0] n);
        return {b, 1'b0, f, e, 1'b0, n, 16'h0000};
    endfunction : mk1
    function automatic logic [30:0] pk(logic f, logic [5:0] k, logic il,
        logic rt, logic [3:0] s, logic [6:0] r, logic sw, logic [1:0] sn,
        logic [1:0] bn, logic [4:0] bl);
        return {f, k, il, rt, s, r, sw, sn, bn, bl, !il};
    endfunction : pk
    task chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            n_fail++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    // one wait state expected, but the count is not assumed
    task av(input logic wr, input logic [3:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge ref_clk);
        avs_address <= a;
        avs_write <= wr;
        avs_read <= !wr;
        avs_writedata <= d;
        do @(posedge ref_clk); while (avs_waitrequest !== 1'b0 && ++n < 50);
        if (n >= 50) n_fail++;
        q = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask : av
    task run(input logic [31:0] w0, w1, input logic [30:0] e, m);
        int n;
        n = 0;
        @(posedge ref_clk);
        ins_valid <= 1'b1;
        ins_word0 <= w0;
        ins_word1 <= w1;
        do @(posedge ref_clk); while (ins_ready !== 1'b1 && ++n < 50);
        ins_valid <= 1'b0;
        while (!(dec_valid === 1'b1 && dec_ready === 1'b1) && n < 60) begin
            @(posedge ref_clk);
            n++;
        end
        if (n >= 50) n_fail++;
        chk({1'b0, m & {dec_program_final_flag, dec_op_kind, dec_illegal,
            dec_returns, dec_view_selector, dec_source_reg_number,
            dec_stream_write, dec_stream_num, dec_buffer_num, dec_burst_len,
            dec_mem_access}}, {1'b0, e & m});
    endtask : run
    task final_report;
        $display("checks=%0d errors=%0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : final_report
    initial begin
        repeat (3000) @(posedge ref_clk);
        n_fail++;
        final_report;
    end
    initial begin
        repeat (16) @(posedge ref_clk);
        rst_n <= 1'b1;
        av(0, 4'h0, 0); chk(q, 32'h1);
        av(1, 4'h1, 32'hff); av(0, 4'h1, 0); chk(q, 32'h0);
        run(mk0(0,0,10,0,1,2), mk1(0,0,8'h50,3),
            pk(0,1,0,0,2,10,0,0,0,4), '1);
        run(mk0(0,1,126,1,36,2), mk1(0,0,8'h49,15),
            pk(0,4,0,1,7,1,1,2,1,16), '1);
        run(mk0(0,0,5,1,20,12), mk1(0,0,8'h50,0),
            pk(0,0,1,0,1,5,0,0,0,1), '1);
        run(mk0(3,0,5,0,2,0), mk1(0,0,8'h50,0),
            pk(0,2,1,0,0,5,0,0,0,1), '1);
        fast <= 1'b1;
        run(mk0(0,0,7,2,51,3), mk1(0,0,8'h4f,0),
            pk(0,19,0,1,12,7,1,3,3,1), '1);
        run(mk0(0,0,0,3,2,0), mk1(0,0,8'h50,0),
            pk(0,0,1,0,0,0,0,0,0,0), 31'h0080_0001);
        run(mk0(0,0,9,0,33,0), mk1(0,0,8'h50,0),
            pk(0,0,1,0,0,9,0,0,0,1), '1);
        run(mk0(0,0,2,0,3,0), mk1(0,0,8'h57,0),
            pk(0,3,1,0,0,2,0,1,3,1), '1);
        prior_done <= 1'b0;
        fork
            run(mk0(1,0,4,0,7,1), mk1(1,0,8'h50,0),
                pk(0,7,0,0,1,4,0,0,0,1), '1);
        join_none
        repeat (4) @(posedge ref_clk);
        chk({31'h0, ins_ready}, 32'h0);
        prior_done <= 1'b1;
        wait fork;
        run(mk0(0,0,3,0,14,0), mk1(0,1,8'h50,1),
            pk(1,14,0,0,0,3,0,0,0,2), '1);
        repeat (2) @(posedge ref_clk);
        chk({31'h0, ins_ready}, 32'h0);
        av(0, 4'h4, 0); chk(q, 32'h7);
        av(0, 4'h8, 0); chk(q, 32'ha);
        av(1, 4'h4, 32'h6); av(1, 4'h0, 32'h3);
        av(0, 4'h4, 0); chk(q, 32'h0);
        av(1, 4'h0, 32'h0);
        @(posedge ref_clk);
        chk({31'h0, ins_ready}, 32'h0);
        av(1, 4'h0, 32'h1);
        run(mk0(0,0,1,0,34,4), mk1(0,0,8'h50,0),
            pk(0,34,0,1,4,1,0,0,0,1), '1);
        final_report;
    end
endmodule : uxd_decoder_bench
